// ### logic/bus_control.v
`timescale 1ns/1ps
`default_nettype none
`include "bus_ctrl_defs.vh"
module bus_control (
    // clock and reset
    input  wire        mclk,
    input  wire        resetn,
    // processor memory port
    input  wire [19:0] cpu_addr,
    input  wire        cpu_wr,
    input  wire        cpu_rd,
    input  wire        cpu_bit_op,
    input  wire [2:0]  cpu_bit_sel,
    input  wire [7:0]  cpu_wdata,
    output reg  [7:0]  cpu_rdata,
    // serial clock line, open drain (oe low = drive low)
    input  wire        serial_clock_line_in,
    output wire        serial_clock_line_out,
    output wire        serial_clock_line_oe_n,
    // serial data line, open drain
    input  wire        serial_data_line_in,
    output wire        serial_data_line_out,
    output wire        serial_data_line_oe_n,
    // events from the shift datapath
    input  wire        addr_match_evt,
    input  wire        ext_code_evt,
    input  wire        master_start_evt,
    input  wire        master_drive_scl,
    input  wire        master_drive_sda,
    // interrupt request and state
    output reg         bus_irq,
    output wire [7:0]  bus_status_register,
    output wire        in_wait,
    output wire        participating
);
    wire scl_s;
    wire sda_s;
    reg  scl_d_r;
    reg  sda_d_r;
    reg  [7:0] bus_control_r;
    reg  [7:0] bus_control_nxt;
    reg  [7:0] status_r;
    reg  [7:0] status_nxt;
    reg  [3:0] clk_cnt_r;
    reg        wait_r;
    reg        released_r;
    reg        link_r;
    reg        link_nxt;

    // bus activity as seen on the lines
    localparam LINK_IDLE = 1'b0;
    localparam LINK_BUSY = 1'b1;

    pin_sync u_scl (
        .mclk    (mclk),
        .resetn  (resetn),
        .pin_in  (serial_clock_line_in),
        .level_r (scl_s)
    );
    pin_sync u_sda (
        .mclk    (mclk),
        .resetn  (resetn),
        .pin_in  (serial_data_line_in),
        .level_r (sda_s)
    );

    wire en         = bus_control_r[`BC_EN];
    wire hit        = (cpu_addr == `BC_ADDR);
    wire wr_hit     = cpu_wr && hit;
    wire rd_hit     = cpu_rd && hit;
    wire scl_fall   = scl_d_r && !scl_s;
    wire scl_rise   = !scl_d_r && scl_s;
    // start and stop need the clock high on two samples, so both lines
    // rising or falling together on enable or release give no condition
    wire scl_high   = scl_d_r && scl_s;
    wire start_cond = scl_high && sda_d_r && !sda_s;
    wire stop_cond  = scl_high && !sda_d_r && sda_s;
    wire rejoin     = (master_start_evt && link_r == LINK_IDLE) ||
                      addr_match_evt || ext_code_evt;

    // merge a bit or byte write into the current value
    function [7:0] merge;
        input [7:0] cur;
        input       bit_op;
        input [2:0] sel;
        input [7:0] wd;
        reg   [7:0] m;
        begin
            m = cur;
            if (bit_op)
                m[sel] = wd[0];
            else
                m = wd;
            merge = m;
        end
    endfunction

    // clock pulse count at which the wait and its interrupt fall
    function [3:0] wait_count;
        input wtim;
        begin
            if (wtim)
                wait_count = `CNT_NINE;
            else
                wait_count = `CNT_EIGHT;
        end
    endfunction

    // clock pulses of a byte and its acknowledge, wrapping after nine
    function [3:0] pulse_next;
        input [3:0] cnt;
        begin
            if (cnt == `CNT_NINE)
                pulse_next = 4'h1;
            else
                pulse_next = cnt + 4'h1;
        end
    endfunction

    wire [7:0] wval   = merge(bus_control_r, cpu_bit_op, cpu_bit_sel,
                              cpu_wdata);
    wire [7:0] wmask  = cpu_bit_op ? (8'h01 << cpu_bit_sel) : 8'hFF;
    wire       rel_go = wr_hit && wmask[`BC_REL] && wval[`BC_REL] && en;
    wire       wrl_go = wr_hit && wmask[`BC_WREL] && wval[`BC_WREL]
                        && en;
    // pulses are counted on rising edges, so the falling edge after a
    // start condition is not taken for a clock
    wire [3:0] wait_at = wait_count(bus_control_r[`BC_WTIM]);
    wire       wait_pt = !wait_r && scl_fall && en && !released_r &&
                         clk_cnt_r == wait_at;

    // control register
    always @* begin
        bus_control_nxt = bus_control_r;
        if (wr_hit) begin
            bus_control_nxt = wval;
            bus_control_nxt[`BC_REL]  = 1'b0;
            bus_control_nxt[`BC_WREL] = 1'b0;
        end
        if (rel_go) begin
            bus_control_nxt[`BC_STT] = 1'b0;
            bus_control_nxt[`BC_SPT] = 1'b0;
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            bus_control_r <= `BC_RESET;
        end else begin
            bus_control_r <= bus_control_nxt;
        end
    end

    // status register
    always @* begin
        status_nxt = status_r;
        if (!en) begin
            status_nxt = `ST_RESET;
        end else begin
            // the release clears first, so an event in the same cycle lands
            if (rel_go) begin
                status_nxt[`ST_STD]  = 1'b0;
                status_nxt[`ST_ACKD] = 1'b0;
                status_nxt[`ST_TRC]  = 1'b0;
                status_nxt[`ST_COI]  = 1'b0;
                status_nxt[`ST_EXC]  = 1'b0;
                status_nxt[`ST_MSTS] = 1'b0;
            end
            if (start_cond) begin
                status_nxt[`ST_STD] = 1'b1;
                status_nxt[`ST_SPD] = 1'b0;
            end
            if (stop_cond) begin
                status_nxt[`ST_SPD] = 1'b1;
            end
            if (addr_match_evt) begin
                status_nxt[`ST_COI] = 1'b1;
            end
            if (ext_code_evt) begin
                status_nxt[`ST_EXC] = 1'b1;
            end
            if (master_start_evt) begin
                status_nxt[`ST_MSTS] = 1'b1;
            end
            // acknowledge level sampled on the ninth rising clock edge
            if (scl_rise && clk_cnt_r == `CNT_EIGHT) begin
                status_nxt[`ST_ACKD] = !sda_s;
            end
        end
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            status_r <= `ST_RESET;
            scl_d_r  <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            status_r <= status_nxt;
            scl_d_r  <= scl_s;
            sda_d_r  <= sda_s;
        end
    end

    // link state: busy from a start condition until a stop condition
    always @* begin
        link_nxt = link_r;
        case (link_r)
            LINK_IDLE: begin
                if (en && start_cond) begin
                    link_nxt = LINK_BUSY;
                end
            end
            LINK_BUSY: begin
                if (!en || stop_cond) begin
                    link_nxt = LINK_IDLE;
                end
            end
            default: begin
                link_nxt = LINK_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!resetn) begin
            link_r <= LINK_IDLE;
        end else begin
            link_r <= link_nxt;
        end
    end

    // clock pulse counter, cleared by start, stop and disable
    always @(posedge mclk) begin
        if (!resetn) begin
            clk_cnt_r <= 4'h0;
        end else if (!en) begin
            clk_cnt_r <= 4'h0;
        end else if (start_cond || stop_cond) begin
            clk_cnt_r <= 4'h0;
        end else if (scl_rise) begin
            clk_cnt_r <= pulse_next(clk_cnt_r);
        end
    end

    // clock-low wait: entered at the selected falling edge, left on command
    always @(posedge mclk) begin
        if (!resetn) begin
            wait_r <= 1'b0;
        end else if (!en) begin
            wait_r <= 1'b0;
        end else if (wait_pt) begin
            wait_r <= 1'b1;
        end else if (wrl_go || rel_go) begin
            wait_r <= 1'b0;
        end
    end

    // withdrawn from the bus after a release until it may take part again
    always @(posedge mclk) begin
        if (!resetn) begin
            released_r <= 1'b0;
        end else if (!en) begin
            released_r <= 1'b0;
        end else if (rel_go) begin
            released_r <= 1'b1;
        end else if (rejoin) begin
            released_r <= 1'b0;
        end
    end

    // interrupt request: one pulse at the wait point or on a stop
    always @(posedge mclk) begin
        if (!resetn) begin
            bus_irq <= 1'b0;
        end else if (!en) begin
            bus_irq <= 1'b0;
        end else if (wait_pt) begin
            bus_irq <= 1'b1;
        end else if (stop_cond && bus_control_r[`BC_SPIE]) begin
            bus_irq <= 1'b1;
        end else begin
            bus_irq <= 1'b0;
        end
    end

    // read data holds until the next read of the register
    always @(posedge mclk) begin
        if (!resetn) begin
            cpu_rdata <= 8'h00;
        end else if (rd_hit) begin
            cpu_rdata <= bus_control_r;
        end
    end

    // open drain outputs: oe_n low pulls the line low
    wire scl_low = !en ||
                   (!released_r && (wait_r || master_drive_scl));
    wire sda_low = !en ||
                   (!released_r && master_drive_sda);
    assign serial_clock_line_out  = 1'b0;
    assign serial_data_line_out   = 1'b0;
    assign serial_clock_line_oe_n = !scl_low;
    assign serial_data_line_oe_n  = !sda_low;
    assign bus_status_register    = status_r;
    assign in_wait                = wait_r;
    assign participating          = en && !released_r;
endmodule // bus_control
`default_nettype wire

// ### logic/bus_ctrl_defs.vh
// Overview of operation
// - reset clears the whole bus control register to zero.
// - processor reads and writes the register at its address, bit or byte.
// - bits 7..0: enable, release, wait release, stop irq, timing, ack, start, stop.
// - enable low presets status, halts operation, drives both lines low.
// - release withdraws from the transfer, waits, leaves both lines released.
// - release clears start, ack, direction, match, extended, master, triggers.
// - release bit self-clears after execution; reset clears it too.
// - after release, rejoin only on master start after stop, address match or extended code.
// - wait release ends the clock-low wait then self-clears; 0 keeps wait.
// - stop irq enable lets a stop condition raise the interrupt request.
// - with enable low, release, wait release and stop irq enable do nothing.
// - stop irq enable set only by software, cleared by software or reset.
// - timing select 0 waits at eighth falling clock edge, 1 at ninth.
`ifndef BUS_CTRL_DEFS_VH
`define BUS_CTRL_DEFS_VH
`define BC_ADDR        20'h0FFB0
`define BC_RESET       8'h00
`define BC_EN          7
`define BC_REL         6
`define BC_WREL        5
`define BC_SPIE        4
`define BC_WTIM        3
`define BC_ACKE        2
`define BC_STT         1
`define BC_SPT         0
`define ST_RESET       8'h00
`define ST_MSTS        7
`define ST_ALD         6
`define ST_EXC         5
`define ST_COI         4
`define ST_TRC         3
`define ST_ACKD        2
`define ST_STD         1
`define ST_SPD         0
`define CNT_EIGHT      4'h8
`define CNT_NINE       4'h9
`endif

// ### logic/pin_sync.v
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser; output changes when stages two and three agree
module pin_sync (
    // clock and reset
    input  wire mclk,
    input  wire resetn,
    // pin and filtered level
    input  wire pin_in,
    output reg  level_r
);
    reg s1_r;
    reg s2_r;
    reg s3_r;
    always @(posedge mclk) begin
        if (!resetn) begin
            s1_r    <= 1'b1;
            s2_r    <= 1'b1;
            s3_r    <= 1'b1;
            level_r <= 1'b1;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                level_r <= s3_r;
        end
    end
endmodule // pin_sync
`default_nettype wire

// ### tb/bus_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "bus_ctrl_defs.vh"
module bus_control_bench;
    logic        mclk, resetn, cpu_wr, cpu_rd, cpu_bit_op, bus_irq;
    logic [19:0] cpu_addr;
    logic [2:0]  cpu_bit_sel;
    logic [7:0]  cpu_wdata, cpu_rdata, bus_status_register, d;
    logic        scl_oe_n, sda_oe_n, in_wait, participating, scl_d, sda_d;
    logic        am_evt, ex_evt, ms_evt, drv_scl, drv_sda, peer_stuck;
    wire         scl = scl_d & scl_oe_n;
    wire         sda = sda_d & sda_oe_n;
    int          err_count, checks, irqs;
    bus_control dut (.mclk, .resetn, .cpu_addr, .cpu_wr, .cpu_rd,
        .cpu_bit_op, .cpu_bit_sel, .cpu_wdata, .cpu_rdata,
        .serial_clock_line_in(scl), .serial_clock_line_out(),
        .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_in(sda),
        .serial_data_line_out(), .serial_data_line_oe_n(sda_oe_n),
        .addr_match_evt(am_evt), .ext_code_evt(ex_evt),
        .master_start_evt(ms_evt), .master_drive_scl(drv_scl),
        .master_drive_sda(drv_sda), .bus_irq,
        .bus_status_register, .in_wait, .participating);
    bus_peer peer (.scl(scl), .scl_d(scl_d), .sda_d(sda_d),
        .stuck(peer_stuck));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) if (bus_irq === 1'b1) irqs++;
    task automatic chk(input logic ok);
        checks++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("BAD %0t unexpected value", $time);
        end
    endtask
    task automatic wr(input logic [19:0] a, input logic bo,
                      input logic [2:0] s, input logic [7:0] v);
        @(negedge mclk);
        cpu_addr = a;
        cpu_bit_op = bo;
        cpu_bit_sel = s;
        cpu_wdata = v;
        cpu_wr = 1'b1;
        @(negedge mclk);
        cpu_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] e);
        @(negedge mclk);
        cpu_addr = `BC_ADDR;
        cpu_rd = 1'b1;
        @(negedge mclk);
        cpu_rd = 1'b0;
        @(negedge mclk);
        chk(cpu_rdata === e);
    endtask
    task automatic wfw(input logic w);
        int j;
        j = 0;
        while (in_wait !== w && j < 40) begin
            @(negedge mclk);
            j++;
        end
        chk(in_wait === w);
    endtask
    task automatic final_report;
        if (err_count == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        {cpu_wr, cpu_rd, cpu_bit_op, resetn} = 4'h0;
        {am_evt, ex_evt, ms_evt, drv_scl, drv_sda} = 5'h00;
        {cpu_addr, cpu_bit_sel, cpu_wdata} = 31'h0;
        void'($urandom(32'hED30D936));
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        rd(8'h00);
        repeat (6) begin
            d = 8'($urandom) & 8'hBC;
            wr(`BC_ADDR, 1'b0, 3'h0, d);
            rd(d & 8'h9C);
        end
        wr(`BC_ADDR + 20'h1, 1'b0, 3'h0, 8'hFF);
        rd(d & 8'h9C);
        wr(`BC_ADDR, 1'b0, 3'h0, 8'h00);
        chk(scl_oe_n === 1'b0 && sda_oe_n === 1'b0);
        wr(`BC_ADDR, 1'b1, 3'h4, 8'h01);
        wr(`BC_ADDR, 1'b1, 3'h7, 8'h01);
        rd(8'h90);
        irqs = 0;
        peer.start_c;
        peer.stop_c;
        repeat (20) @(negedge mclk);
        chk(irqs == 1);
        wr(`BC_ADDR, 1'b1, 3'h4, 8'h00);
        peer.start_c;
        peer.stop_c;
        repeat (20) @(negedge mclk);
        chk(irqs == 1);
        peer.start_c;
        peer.clocks(8);
        wfw(1'b1);
        repeat (20) @(negedge mclk);
        chk(in_wait === 1'b1 && scl === 1'b0);
        wr(`BC_ADDR, 1'b0, 3'h0, 8'hA0);
        wfw(1'b0);
        peer.clocks(1);
        peer.stop_c;
        wr(`BC_ADDR, 1'b0, 3'h0, 8'h88);
        peer.start_c;
        peer.clocks(8);
        repeat (10) @(negedge mclk);
        chk(in_wait === 1'b0);
        peer.clocks(1);
        wfw(1'b1);
        wr(`BC_ADDR, 1'b0, 3'h0, 8'hC8);
        chk(!in_wait && !participating && scl_oe_n && sda_oe_n);
        chk((bus_status_register & 8'hBE) === 8'h00);
        rd(8'h88);
        am_evt = 1'b1;
        @(negedge mclk);
        am_evt = 1'b0;
        chk(participating === 1'b1);
        wr(`BC_ADDR, 1'b1, 3'h6, 8'h01);
        ms_evt = 1'b1;
        @(negedge mclk);
        ms_evt = 1'b0;
        chk(participating === 1'b0);
        peer.stop_c;
        repeat (8) @(negedge mclk);
        ms_evt = 1'b1;
        @(negedge mclk);
        ms_evt = 1'b0;
        chk(participating === 1'b1);
        wr(`BC_ADDR, 1'b1, 3'h6, 8'h01);
        ex_evt = 1'b1;
        @(negedge mclk);
        ex_evt = 1'b0;
        chk(participating === 1'b1);
        drv_scl = 1'b1;
        drv_sda = 1'($urandom);
        @(negedge mclk);
        chk(scl_oe_n === 1'b0 && sda_oe_n === !drv_sda);
        wr(`BC_ADDR, 1'b1, 3'h6, 8'h01);
        chk(scl_oe_n === 1'b1 && sda_oe_n === 1'b1);
        chk(peer_stuck === 1'b0);
        final_report;
    end
endmodule // bus_control_bench
`default_nettype wire

// ### tb/bus_peer.sv
`timescale 1ns/1ps
`default_nettype none
module bus_peer (
    // resolved clock level and own pull-downs
    input  wire logic scl,
    output var logic  scl_d,
    output var logic  sda_d,
    // set when a stretched clock never came back
    output var logic  stuck
);
    initial {scl_d, sda_d, stuck} = 3'b110;
    task automatic start_c;
        sda_d = 1'b0;
        #40 scl_d = 1'b0;
    endtask
    // data changes only while the clock is low; stretching is honoured
    task automatic clocks(input int n);
        int j;
        repeat (n) begin
            sda_d = 1'($urandom);
            #40 scl_d = 1'b1;
            j = 0;
            while (scl !== 1'b1 && j < 300) begin
                #10 j++;
            end
            if (j >= 300) stuck = 1'b1;
            #40 scl_d = 1'b0;
        end
    endtask
    task automatic stop_c;
        #20 sda_d = 1'b0;
        #20 scl_d = 1'b1;
        #40 sda_d = 1'b1;
        #40;
    endtask
endmodule // bus_peer
`default_nettype wire

// ### tb/bus_watch_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "bus_ctrl_defs.vh"
module bus_watch (
    // clock, reset and processor port
    input wire logic        mclk, resetn, cpu_wr, cpu_rd, cpu_bit_op,
    input wire logic        addr_match_evt, ext_code_evt, master_start_evt,
    input wire logic [19:0] cpu_addr,
    input wire logic [7:0]  cpu_wdata, cpu_rdata, bus_status_register,
    // line enables and state
    input wire logic        serial_clock_line_oe_n, serial_data_line_oe_n,
    input wire logic        bus_irq, in_wait, participating
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    logic hit, bw, was_rst_r;
    assign hit = cpu_addr == `BC_ADDR;
    assign bw = cpu_wr && hit && !cpu_bit_op;
    always @(posedge mclk) was_rst_r <= !resetn;
    AST_RST_ZERO: assert property (was_rst_r |-> cpu_rdata == 8'h00
        && bus_status_register == 8'h00) else $error("reset value");
    AST_OFF_LOW: assert property (bw && !cpu_wdata[7] |=>
        !serial_clock_line_oe_n && !serial_data_line_oe_n)
        else $error("lines not low");
    AST_CMD_RD0: assert property (cpu_rd && hit |=>
        cpu_rdata[6:5] == 2'b00) else $error("command bit reads 1");
    AST_RELEASE: assert property (participating && bw &&
        cpu_wdata[7:6] == 2'b11 && !addr_match_evt && !ext_code_evt
        && !master_start_evt |=> (bus_status_register & 8'hBE) == 8'h00
        && !in_wait && serial_clock_line_oe_n && serial_data_line_oe_n
        && !participating) else $error("release incomplete");
    AST_IRQ_PULSE: assert property (bus_irq |=> !bus_irq)
        else $error("irq too long");
    AST_WAIT_LOW: assert property (in_wait |-> !serial_clock_line_oe_n)
        else $error("wait without clock low");
    AST_WAIT_KEEP: assert property (in_wait && !(cpu_wr && hit)
        |=> in_wait) else $error("wait dropped");
    AST_WAIT_END: assert property (in_wait && bw && cpu_wdata[7]
        && cpu_wdata[5] |=> !in_wait) else $error("wait not ended");
endmodule // bus_watch
bind bus_control bus_watch chk (.*);
`default_nettype wire
